// ===== include/phylc_pkg.sv
// Constants, types and register map of the strap and link control block.
// Assumes one 125 MHz clock and strap levels already resolved to mode codes.
// How it works
// - Strap levels are captured once after hardware reset release, then held.
// - Software reset reloads strap settings from the held capture, not pins.
// - Each strap is one of four modes, mode N gives two-bit value N-1.
// - Every strap setting can also be written over management registers.
// - Third LED strap sets transmit skew bits 1:0, mode 1..4 gives 00..11.
// - Fast link modes live in the fast link config register at 0x001E.
// - Gigabit fast modes act only at 1000, the others only at 100.
// - With downshift on, drop to 100 after set number of gigabit failures.
// - Failure threshold resets to four consecutive gigabit attempts.
// - Enhanced mode drops after one failure if channels C and D are quiet.
// - Downshift may fall further to 10 when 100 also fails.
// - Downshift does nothing unless its enable bit is set.
// - Mirroring at 10/100 routes A to D and B to C.
// - Mirroring at 1000 swaps A with D and B with C.
// - Mirrored channels also have their polarity inverted.
// - Mirroring is enabled by strap or by bit 0 of register 0x0031.
// - Interrupt output follows status changes gated by the enable register.
// - Normal plus four gigabit test modes selected in register 0x0009.
// - In a test mode the pattern drives the media, with a synchronous clock.
// - Management address: addr high strap gives bits 3:2, low gives 1:0.
// - With no strap fitted the management address is zero.
package phylc_pkg;
  localparam int SYM_W = 8;
  localparam logic [15:0] REG_TEST_MODE = 16'h0009;
  localparam logic [15:0] REG_EXT_CTRL = 16'h000D;
  localparam logic [15:0] REG_EXT_DATA = 16'h000E;
  localparam logic [15:0] REG_INT_EN = 16'h0012;
  localparam logic [15:0] REG_INT_STS = 16'h0013;
  localparam logic [15:0] REG_FAST_LINK = 16'h001E;
  localparam logic [15:0] REG_MIRROR_STRAP = 16'h0031;
  // test_mode_config fields
  localparam int TM_MODE_HI = 15;
  localparam int TM_MODE_LO = 13;
  localparam int TM_DS_EN = 12;
  localparam int TM_DS_THR_HI = 11;
  localparam int TM_DS_THR_LO = 10;
  localparam int TM_DS_ENH = 9;
  localparam int TM_DS_10M = 8;
  localparam int TM_TDR = 7;
  localparam logic [15:0] TM_RST = 16'h0C00;
  // mirror_and_strap_config fields
  localparam int MS_ADDR_HI = 15;
  localparam int MS_ADDR_LO = 12;
  localparam int MS_ANEG_DIS = 7;
  localparam int MS_SKEW_HI = 3;
  localparam int MS_SKEW_LO = 2;
  localparam int MS_MIRROR = 0;
  // fast_link_config fields
  localparam int FL_GIG_HI = 1;
  localparam int FL_GIG_LO = 0;
  localparam int FL_100_HI = 3;
  localparam int FL_100_LO = 2;
  localparam logic [15:0] FL_RST = 16'h0000;
  // interrupt sources
  localparam int INT_W = 4;
  localparam int INT_LINK = 0;
  localparam int INT_SPEED = 1;
  localparam int INT_DS = 2;
  localparam int INT_ENERGY = 3;
  localparam logic [15:0] INT_EN_RST = 16'h0000;
  // management frame
  localparam logic [5:0] PREAMBLE_LEN = 6'h20;
  localparam logic [4:0] HDR_LAST = 5'h0C;
  localparam logic [4:0] DATA_LAST = 5'h0F;
  localparam logic [1:0] OP_READ = 2'h2;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [1:0] EXT_FN_ADDR = 2'h0;
  localparam logic [1:0] STRAP_SETTLE = 2'h3;
  localparam logic [1:0] MODE4 = 2'h3;
  localparam logic [2:0] DS_ONE = 3'h1;
  // media symbols and test pattern
  localparam logic [SYM_W-1:0] SYM_POS2 = 8'h02;
  localparam logic [SYM_W-1:0] SYM_NEG2 = 8'hFE;
  localparam logic [10:0] LFSR_SEED = 11'h7FF;
  localparam int LFSR_TAP = 8;
  localparam int WAVE_W = 7;
  localparam int CH_A = 0;
  localparam int CH_B = 1;
  localparam int CH_C = 2;
  localparam int CH_D = 3;

  typedef enum logic [1:0] {
    SPD_10 = 2'b00,
    SPD_100 = 2'b01,
    SPD_1000 = 2'b10
  } phylc_speed_e;
  typedef enum logic [2:0] {
    MD_PRE = 3'b000,
    MD_HDR = 3'b001,
    MD_TA = 3'b010,
    MD_RDATA = 3'b011,
    MD_WDATA = 3'b100
  } phylc_mdio_e;
  typedef enum logic [2:0] {
    TM_NORMAL = 3'b000,
    TM_WAVE = 3'b001,
    TM_JIT_M = 3'b010,
    TM_JIT_S = 3'b011,
    TM_DIST = 3'b100
  } phylc_test_e;
  typedef struct packed {
    logic [1:0] addr_lo;
    logic [1:0] addr_hi;
    logic [1:0] rx_ctrl;
    logic [1:0] led2;
    logic [1:0] led0;
  } phylc_strap_s;
  typedef struct packed {
    logic [3:0][SYM_W-1:0] ch;
  } phylc_mdi_s;
endpackage

// ===== src/phylc_top.sv
// Strap capture, management registers, downshift, mirroring and test modes.
// Assumes straps arrive as resolved two-bit mode codes and link events are
// one-cycle pulses from core logic on CLK_I.
module phylc_top
  import phylc_pkg::*;
(
  input wire logic CLK_I, // 125 MHz
  input wire logic RST_B_I, // Hardware reset, async, low
  input wire logic SW_RESET_I, // Software reset pulse
  input wire phylc_strap_s STRAP_I, // Strap mode codes from pins
  input wire logic MDC_I, // Management clock pin
  input wire logic MDIO_I, // Management data pin in
  output logic MDIO_O, // Management data pin out
  output logic MDIO_OE_O, // Management data drive enable
  input wire logic LINK_UP_I, // Link status level
  input wire logic ENERGY_CD_I, // Energy seen on channels C and D
  input wire logic GIG_FAIL_I, // Gigabit attempt failed pulse
  input wire logic FAIL_100_I, // 100 attempt failed pulse
  input wire phylc_mdi_s TX_SYM_I, // Transmit symbols per channel
  output phylc_mdi_s TX_SYM_O, // Symbols to the media pins
  output phylc_speed_e SPEED_O, // Speed being attempted
  output logic ANEG_DIS_O, // Auto-negotiation disabled
  output logic [1:0] TX_SKEW_O, // Transmit clock skew bits 1:0
  output logic [3:0] MGMT_ADDR_O, // Management address
  output logic MIRROR_O, // Mirroring active
  output logic [1:0] FAST_GIG_O, // Gigabit fast link modes
  output logic [1:0] FAST_100_O, // 100 fast link modes
  output logic TDR_AUTO_O, // Run cable test on link loss
  output logic TEST_CLK_O, // Test pattern clock
  output logic INT_B_O // Interrupt, low active
);
  logic [2:0] mdc_s, mdio_s;
  logic [2:0][9:0] strap_s;
  logic mdc_lvl_r, mdc_rise;
  logic [1:0] settle_r;
  logic strap_done_r, strap_load_r;
  phylc_strap_s latch_r;
  logic [15:0] tm_r, fl_r, ms_r, ie_r, ext_ctrl_r, ext_addr_r;
  logic [INT_W-1:0] is_r, int_set;
  phylc_mdio_e md_r;
  logic [5:0] ones_r;
  logic [4:0] bcnt_r;
  logic [15:0] sh_r;
  logic rd_r;
  logic [4:0] reg_r;
  logic wr_stb_r, rd_clr_r;
  logic [15:0] wr_data_r;
  logic [4:0] wr_reg_r;
  logic [15:0] rd_word, acc_addr;
  phylc_speed_e speed_r, speed_nxt;
  logic [2:0] fails_r, fails_nxt;
  logic link_d_r, energy_d_r, ds_evt;
  logic [10:0] lfsr_r;
  logic [WAVE_W-1:0] wave_r;
  phylc_test_e tmode;
  logic test_on;

  // Pin synchronisers, three stages each
  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      mdc_s <= '0;
      mdio_s <= '0;
      strap_s <= '0;
    end else begin
      mdc_s <= {mdc_s[1:0], MDC_I};
      mdio_s <= {mdio_s[1:0], MDIO_I};
      strap_s <= {strap_s[1:0], STRAP_I};
    end
  end

  assign mdc_rise = (mdc_s[1] == mdc_s[2]) && mdc_s[2] && !mdc_lvl_r;

  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) mdc_lvl_r <= 1'b0;
    else if (mdc_s[1] == mdc_s[2]) mdc_lvl_r <= mdc_s[2];
  end

  // Strap capture once the synchroniser has filled after reset release
  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      settle_r <= '0;
      strap_done_r <= 1'b0;
      latch_r <= '0;
      strap_load_r <= 1'b0;
    end else if (!strap_done_r) begin
      settle_r <= settle_r + 2'h1;
      strap_load_r <= (settle_r == STRAP_SETTLE);
      if (settle_r == STRAP_SETTLE) begin
        strap_done_r <= 1'b1;
        latch_r <= strap_s[2];
      end
    end else begin
      strap_load_r <= 1'b0;
    end
  end

  // Management frame engine
  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      md_r <= MD_PRE;
      ones_r <= '0;
      bcnt_r <= '0;
      sh_r <= '0;
      rd_r <= 1'b0;
      reg_r <= '0;
      MDIO_O <= 1'b0;
      MDIO_OE_O <= 1'b0;
      wr_stb_r <= 1'b0;
      rd_clr_r <= 1'b0;
      wr_data_r <= '0;
      wr_reg_r <= '0;
    end else begin
      wr_stb_r <= 1'b0;
      rd_clr_r <= 1'b0;
      if (mdc_rise) begin
        unique case (md_r)
          MD_PRE: begin
            if (mdio_s[2]) begin
              if (ones_r != PREAMBLE_LEN) ones_r <= ones_r + 6'h01;
            end else begin
              ones_r <= '0;
              bcnt_r <= '0;
              if (ones_r == PREAMBLE_LEN) md_r <= MD_HDR;
            end
          end
          MD_HDR: begin
            sh_r <= {sh_r[14:0], mdio_s[2]};
            bcnt_r <= bcnt_r + 5'h01;
            if (bcnt_r == HDR_LAST) begin
              bcnt_r <= '0;
              reg_r <= {sh_r[3:0], mdio_s[2]};
              rd_r <= (sh_r[10:9] == OP_READ);
              md_r <= MD_PRE;
              if (sh_r[11] && sh_r[8:4] == {1'b0, MGMT_ADDR_O} &&
                  (sh_r[10:9] == OP_READ || sh_r[10:9] == OP_WRITE))
                md_r <= MD_TA;
            end
          end
          MD_TA: begin
            bcnt_r <= bcnt_r + 5'h01;
            if (rd_r && bcnt_r == '0) begin
              MDIO_OE_O <= 1'b1;
              MDIO_O <= 1'b0;
            end
            if (bcnt_r != '0) begin
              bcnt_r <= '0;
              md_r <= rd_r ? MD_RDATA : MD_WDATA;
              if (rd_r) begin
                MDIO_O <= rd_word[15];
                sh_r <= rd_word;
                rd_clr_r <= (acc_addr == REG_INT_STS);
              end
            end
          end
          MD_RDATA: begin
            bcnt_r <= bcnt_r + 5'h01;
            sh_r <= {sh_r[14:0], 1'b0};
            MDIO_O <= sh_r[14];
            if (bcnt_r == DATA_LAST) begin
              MDIO_OE_O <= 1'b0;
              MDIO_O <= 1'b0;
              md_r <= MD_PRE;
            end
          end
          MD_WDATA: begin
            bcnt_r <= bcnt_r + 5'h01;
            sh_r <= {sh_r[14:0], mdio_s[2]};
            if (bcnt_r == DATA_LAST) begin
              wr_stb_r <= 1'b1;
              wr_reg_r <= reg_r;
              wr_data_r <= {sh_r[14:0], mdio_s[2]};
              md_r <= MD_PRE;
            end
          end
          default: md_r <= MD_PRE;
        endcase
      end
    end
  end

  // Direct or indirect register address for the frame in progress
  always_comb begin
    acc_addr = {11'h000, reg_r};
    if ({11'h000, reg_r} == REG_EXT_DATA &&
        ext_ctrl_r[15:14] != EXT_FN_ADDR)
      acc_addr = ext_addr_r;
  end

  always_comb begin
    rd_word = '0;
    if ({11'h000, reg_r} == REG_EXT_DATA &&
        ext_ctrl_r[15:14] == EXT_FN_ADDR)
      rd_word = ext_addr_r;
    else if ({11'h000, reg_r} == REG_EXT_CTRL)
      rd_word = ext_ctrl_r;
    else if (acc_addr == REG_TEST_MODE)
      rd_word = tm_r;
    else if (acc_addr == REG_INT_EN)
      rd_word = ie_r;
    else if (acc_addr == REG_INT_STS)
      rd_word = {{(16 - INT_W){1'b0}}, is_r};
    else if (acc_addr == REG_FAST_LINK)
      rd_word = fl_r;
    else if (acc_addr == REG_MIRROR_STRAP)
      rd_word = ms_r;
  end

  // Configuration registers, strap reload and register overrides
  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      tm_r <= TM_RST;
      fl_r <= FL_RST;
      ie_r <= INT_EN_RST;
      ms_r <= '0;
      ext_ctrl_r <= '0;
      ext_addr_r <= '0;
    end else if (strap_load_r || SW_RESET_I) begin
      tm_r <= TM_RST;
      fl_r <= FL_RST;
      ie_r <= INT_EN_RST;
      ext_ctrl_r <= '0;
      ext_addr_r <= '0;
      ms_r <= '0;
      ms_r[MS_ADDR_HI:MS_ADDR_LO] <= {latch_r.addr_hi, latch_r.addr_lo};
      ms_r[MS_ANEG_DIS] <= (latch_r.rx_ctrl == MODE4);
      ms_r[MS_SKEW_HI:MS_SKEW_LO] <= latch_r.led2;
      ms_r[MS_MIRROR] <= latch_r.led0[1];
    end else if (wr_stb_r) begin
      if ({11'h000, wr_reg_r} == REG_EXT_CTRL)
        ext_ctrl_r <= wr_data_r;
      else if ({11'h000, wr_reg_r} == REG_EXT_DATA &&
               ext_ctrl_r[15:14] == EXT_FN_ADDR)
        ext_addr_r <= wr_data_r;
      else if (acc_addr == REG_TEST_MODE)
        tm_r <= wr_data_r;
      else if (acc_addr == REG_INT_EN)
        ie_r <= wr_data_r;
      else if (acc_addr == REG_FAST_LINK)
        fl_r <= wr_data_r;
      else if (acc_addr == REG_MIRROR_STRAP)
        ms_r <= wr_data_r;
    end
  end

  // Downshift: count consecutive failed gigabit attempts
  always_comb begin
    speed_nxt = speed_r;
    fails_nxt = fails_r;
    ds_evt = 1'b0;
    if (!tm_r[TM_DS_EN]) begin
      speed_nxt = SPD_1000;
      fails_nxt = '0;
    end else if (LINK_UP_I) begin
      fails_nxt = '0;
    end else if (GIG_FAIL_I && speed_r == SPD_1000) begin
      fails_nxt = fails_r + DS_ONE;
      if ((tm_r[TM_DS_ENH] && !ENERGY_CD_I) ||
          fails_nxt == {1'b0, tm_r[TM_DS_THR_HI:TM_DS_THR_LO]} + DS_ONE) begin
        speed_nxt = SPD_100;
        fails_nxt = '0;
        ds_evt = 1'b1;
      end
    end else if (FAIL_100_I && speed_r == SPD_100 && tm_r[TM_DS_10M]) begin
      speed_nxt = SPD_10;
      ds_evt = 1'b1;
    end
  end

  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      speed_r <= SPD_1000;
      fails_r <= '0;
    end else begin
      speed_r <= speed_nxt;
      fails_r <= fails_nxt;
    end
  end

  // Sticky interrupt status; a new event wins over the read clear
  assign int_set = {strap_done_r && (ENERGY_CD_I != energy_d_r), ds_evt,
                    speed_nxt != speed_r,
                    strap_done_r && (LINK_UP_I != link_d_r)};

  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      is_r <= '0;
      link_d_r <= 1'b0;
      energy_d_r <= 1'b0;
      INT_B_O <= 1'b1;
    end else begin
      link_d_r <= LINK_UP_I;
      energy_d_r <= ENERGY_CD_I;
      is_r <= (rd_clr_r ? '0 : is_r) | int_set;
      INT_B_O <= ~|(is_r & ie_r[INT_W-1:0]);
    end
  end

  // Test pattern generators
  assign tmode = phylc_test_e'(tm_r[TM_MODE_HI:TM_MODE_LO]);
  assign test_on = (tmode != TM_NORMAL) && (speed_r == SPD_1000);

  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      lfsr_r <= LFSR_SEED;
      wave_r <= '0;
      TEST_CLK_O <= 1'b0;
    end else if (test_on) begin
      lfsr_r <= {lfsr_r[9:0], lfsr_r[10] ^ lfsr_r[LFSR_TAP]};
      wave_r <= wave_r + {{(WAVE_W - 1){1'b0}}, 1'b1};
      TEST_CLK_O <= ~TEST_CLK_O;
    end else begin
      TEST_CLK_O <= 1'b0;
    end
  end

  // Media lane mapping, one generate entry per channel
  for (genvar g = 0; g < 4; g++) begin : g_lane
    logic [SYM_W-1:0] pat, src;
    always_comb begin
      pat = SYM_NEG2;
      unique case (tmode)
        TM_NORMAL: pat = SYM_NEG2;
        TM_WAVE: pat = wave_r[WAVE_W-1] ? SYM_POS2 : SYM_NEG2;
        TM_JIT_M, TM_JIT_S: pat = TEST_CLK_O ? SYM_POS2 : SYM_NEG2;
        TM_DIST: pat = lfsr_r[g] ? SYM_POS2 : SYM_NEG2;
        default: pat = SYM_NEG2;
      endcase
      src = TX_SYM_I.ch[g];
      if (MIRROR_O) begin
        src = -TX_SYM_I.ch[3 - g];
        if (speed_r != SPD_1000 && g < CH_C)
          src = '0;
      end
    end
    always_ff @(posedge CLK_I or negedge RST_B_I) begin
      if (!RST_B_I) TX_SYM_O.ch[g] <= '0;
      else TX_SYM_O.ch[g] <= test_on ? pat : src;
    end
  end

  assign SPEED_O = speed_r;
  assign ANEG_DIS_O = ms_r[MS_ANEG_DIS];
  assign TX_SKEW_O = ms_r[MS_SKEW_HI:MS_SKEW_LO];
  assign MGMT_ADDR_O = ms_r[MS_ADDR_HI:MS_ADDR_LO];
  assign MIRROR_O = ms_r[MS_MIRROR];
  assign FAST_GIG_O = (speed_r == SPD_1000) ?
                      fl_r[FL_GIG_HI:FL_GIG_LO] : 2'h0;
  assign FAST_100_O = (speed_r == SPD_100) ?
                      fl_r[FL_100_HI:FL_100_LO] : 2'h0;
  assign TDR_AUTO_O = tm_r[TM_TDR];

  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RST_B_I);

  sequence s_captured;
    $rose(strap_done_r);
  endsequence

  a_strap_hold: assert property (strap_done_r |=> $stable(latch_r))
    else $error("strap capture changed after it was taken");
  a_soft_reload: assert property (SW_RESET_I |=>
      MGMT_ADDR_O == {latch_r.addr_hi, latch_r.addr_lo})
    else $error("software reset did not reload address");
  a_skew_strap: assert property (s_captured |=> TX_SKEW_O == latch_r.led2)
    else $error("skew not taken from third led strap");
  a_ds_off: assert property (!tm_r[TM_DS_EN] |=> SPEED_O == SPD_1000)
    else $error("speed changed with downshift off");
  a_ds_enh: assert property (tm_r[TM_DS_EN] && tm_r[TM_DS_ENH] &&
      !LINK_UP_I && GIG_FAIL_I && !ENERGY_CD_I && speed_r == SPD_1000
      |=> SPEED_O == SPD_100)
    else $error("enhanced downshift missed");
  a_mirror_gig: assert property (MIRROR_O && !test_on &&
      speed_r == SPD_1000 |=> TX_SYM_O.ch[CH_D] == -$past(TX_SYM_I.ch[CH_A]))
    else $error("gigabit mirror mapping wrong");
  a_mirror_fast: assert property (MIRROR_O && speed_r != SPD_1000
      |=> TX_SYM_O.ch[CH_C] == -$past(TX_SYM_I.ch[CH_B]))
    else $error("10/100 mirror mapping wrong");
  a_int_gate: assert property (|(is_r & ie_r[INT_W-1:0]) ##1
      (is_r != '0 || !INT_B_O) |-> !INT_B_O)
    else $error("enabled status did not raise interrupt");
  a_fast_gate: assert property (speed_r != SPD_100 |-> FAST_100_O == 2'h0)
    else $error("100 fast mode applied at wrong speed");
  a_test_clk: assert property (test_on [*3] |->
      TEST_CLK_O != $past(TEST_CLK_O))
    else $error("test clock not toggling");
endmodule

// ===== verif/phylc_link_partner.sv
// Link partner model: reports the outcome of each link attempt ordered.
// Assumes the block's clock and reset, and attempts that never succeed.
module phylc_link_partner
  import phylc_pkg::*;
(
  input wire logic clk_i, // Shared clock
  input wire logic rst_b_i, // Reset, low
  input wire phylc_speed_e speed_i, // Speed being tried
  input wire logic try_i, // Make one attempt
  input wire logic quiet_cd_i, // Nothing sent on C and D
  output logic link_up_o, // Link status
  output logic energy_cd_o, // Energy on C and D
  output logic gig_fail_o, // Gigabit attempt failed
  output logic fail_100_o // 100 attempt failed
);
  timeunit 1ns;
  timeprecision 100ps;
  // Every attempt fails, so the link never comes up
  assign link_up_o = 1'b0;
  assign energy_cd_o = !quiet_cd_i;
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      gig_fail_o <= 1'b0;
      fail_100_o <= 1'b0;
    end else begin
      gig_fail_o <= try_i && (speed_i == SPD_1000);
      fail_100_o <= try_i && (speed_i == SPD_100);
    end
  end
endmodule

// ===== verif/testbench.sv
// Bench for the strap and link control block: straps, management frames,
// downshift, mirroring, interrupt and test modes.
// Assumes the package is compiled first and the partner model beside it.
module testbench
  import phylc_pkg::*;
  ;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic sw_rst = 1'b0;
  logic mdc = 1'b0;
  logic drv = 1'b1;
  logic try_r = 1'b0;
  logic quiet = 1'b0;
  phylc_strap_s strap = '{addr_lo: 2'h1, addr_hi: 2'h2, rx_ctrl: 2'h3,
                          led2: 2'h3, led0: 2'h0};
  phylc_mdi_s tx_in = '0;
  phylc_mdi_s tx_out;
  phylc_speed_e speed;
  logic mdio_o, mdio_oe, link_up, energy, gfail, f100, aneg, mir, tclk;
  logic int_b, tdr, mdio_w;
  logic [1:0] skew, fgig, f100m;
  logic [3:0] addr;
  int fail_count = 0;
  int check_count = 0;

  // Management line has a pull-up while nobody drives it
  assign mdio_w = mdio_oe ? mdio_o : drv;
  always #4 clk = ~clk;

  phylc_top dut (
    .CLK_I(clk), .RST_B_I(rst_b), .SW_RESET_I(sw_rst), .STRAP_I(strap),
    .MDC_I(mdc), .MDIO_I(mdio_w), .MDIO_O(mdio_o), .MDIO_OE_O(mdio_oe),
    .LINK_UP_I(link_up), .ENERGY_CD_I(energy), .GIG_FAIL_I(gfail),
    .FAIL_100_I(f100), .TX_SYM_I(tx_in), .TX_SYM_O(tx_out),
    .SPEED_O(speed), .ANEG_DIS_O(aneg), .TX_SKEW_O(skew),
    .MGMT_ADDR_O(addr), .MIRROR_O(mir), .FAST_GIG_O(fgig),
    .FAST_100_O(f100m), .TDR_AUTO_O(tdr), .TEST_CLK_O(tclk),
    .INT_B_O(int_b)
  );
  phylc_link_partner lp (
    .clk_i(clk), .rst_b_i(rst_b), .speed_i(speed), .try_i(try_r),
    .quiet_cd_i(quiet), .link_up_o(link_up), .energy_cd_o(energy),
    .gig_fail_o(gfail), .fail_100_o(f100)
  );

  task automatic chk(input string nm, input logic [31:0] seen,
                     input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // One management bit: data set while MDC is low, line sampled before rise
  task automatic mbit(input logic b, output logic s);
    mdc = 1'b0;
    drv = b;
    cyc(5);
    s = mdio_w;
    mdc = 1'b1;
    cyc(5);
  endtask
  task automatic frame(input logic [1:0] op, input logic [4:0] rg,
                       input logic [15:0] wd, output logic [15:0] rd);
    logic [63:0] v;
    logic s;
    v = {32'hFFFFFFFF, 2'b01, op, 5'h09, rg,
         (op == OP_WRITE) ? {2'b10, wd} : 18'h3FFFF};
    for (int i = 63; i >= 0; i--) begin
      mbit(v[i], s);
      if (i < 16) rd[i] = s;
    end
    mbit(1'b1, s);
  endtask
  task automatic wr(input logic [4:0] rg, input logic [15:0] d);
    logic [15:0] q;
    frame(OP_WRITE, rg, d, q);
  endtask
  task automatic rd(input logic [4:0] rg, output logic [15:0] q);
    frame(OP_READ, rg, 16'h0000, q);
  endtask
  task automatic attempt(input int n);
    repeat (n) begin
      try_r = 1'b1;
      cyc(1);
      try_r = 1'b0;
      cyc(3);
    end
  endtask

  task automatic t_straps();
    logic [15:0] q;
    chk("addr", 32'(addr), 32'h9);
    chk("skew", 32'(skew), 32'h3);
    chk("aneg", 32'(aneg), 32'h1);
    chk("mirror", 32'(mir), 32'h0);
    strap = '0;
    cyc(10);
    chk("addr held", 32'(addr), 32'h9);
    rd(5'h09, q);
    chk("r09", 32'(q), 32'h0C00);
    rd(5'h13, q);
    chk("r13", 32'(q), 32'h0);
    rd(5'h05, q);
    chk("unmapped", 32'(q), 32'h0);
  endtask
  task automatic t_mirror();
    tx_in.ch = {8'h04, 8'h03, 8'h02, 8'h01};
    cyc(3);
    chk("pass", 32'(tx_out), 32'h04030201);
    wr(5'h0D, 16'h0000);
    wr(5'h0E, 16'h0031);
    wr(5'h0D, 16'h4000);
    wr(5'h0E, 16'h9005);
    cyc(3);
    chk("skew wr", 32'(skew), 32'h1);
    chk("aneg wr", 32'(aneg), 32'h0);
    chk("mir on", 32'(mir), 32'h1);
    chk("mir 1000", 32'(tx_out), 32'hFFFEFDFC);
  endtask
  task automatic t_downshift();
    logic [15:0] q;
    wr(5'h1E, 16'h000E);
    wr(5'h12, 16'h0004);
    attempt(5);
    chk("ds off", 32'(speed), 32'h2);
    chk("fast 1000", 32'({fgig, f100m}), 32'h8);
    rd(5'h1E, q);
    chk("r1e", 32'(q), 32'h000E);
    wr(5'h09, 16'h1C00);
    attempt(3);
    chk("ds 3", 32'(speed), 32'h2);
    chk("int idle", 32'(int_b), 32'h1);
    attempt(1);
    chk("ds 4", 32'(speed), 32'h1);
    chk("int low", 32'(int_b), 32'h0);
    chk("fast 100", 32'({fgig, f100m}), 32'h3);
    chk("mir 100", 32'(tx_out), 32'hFFFE0000);
    rd(5'h13, q);
    chk("r13 ds", 32'(q), 32'h6);
    chk("int clr", 32'(int_b), 32'h1);
    wr(5'h09, 16'h1D00);
    attempt(1);
    chk("ds 10", 32'(speed), 32'h0);
    wr(5'h09, 16'h0C00);
    cyc(2);
    chk("ds dis", 32'(speed), 32'h2);
    quiet = 1'b1;
    wr(5'h09, 16'h1E00);
    attempt(1);
    chk("ds enh", 32'(speed), 32'h1);
    rd(5'h13, q);
    chk("r13 enh", 32'(q), 32'hE);
    wr(5'h09, 16'h0C00);
    quiet = 1'b0;
  endtask
  task automatic t_swreset();
    sw_rst = 1'b1;
    cyc(1);
    sw_rst = 1'b0;
    cyc(2);
    chk("sw skew", 32'(skew), 32'h3);
    chk("sw addr", 32'(addr), 32'h9);
    chk("sw aneg", 32'(aneg), 32'h1);
    chk("sw mir", 32'(mir), 32'h0);
  endtask
  task automatic t_testmode();
    logic t;
    for (int m = 1; m <= 4; m++) begin
      wr(5'h09, {m[2:0], 13'h0C00});
      t = tclk;
      cyc(1);
      chk("tclk", 32'(t ^ tclk), 32'h1);
    end
    wr(5'h09, 16'h4C00);
    t = (tx_out.ch[0] == (tclk ? SYM_NEG2 : SYM_POS2));
    chk("pattern", 32'(t), 32'h1);
    wr(5'h09, 16'h0C80);
    cyc(2);
    chk("tdr", 32'(tdr), 32'h1);
    chk("normal", 32'(tclk), 32'h0);
    chk("normal tx", 32'(tx_out), 32'h04030201);
  endtask
  task automatic t_hwreset();
    rst_b = 1'b0;
    cyc(8);
    rst_b = 1'b1;
    cyc(8);
    chk("addr zero", 32'(addr), 32'h0);
    chk("skew zero", 32'(skew), 32'h0);
  endtask

  task automatic test_done();
    $display("checks %0d errors %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  initial begin
    cyc(8);
    rst_b = 1'b1;
    cyc(8);
    t_straps();
    t_mirror();
    t_downshift();
    t_swreset();
    t_testmode();
    t_hwreset();
    test_done();
  end
  // Cuts a hang short
  initial begin
    #600000;
    fail_count++;
    test_done();
  end
endmodule
